// ---- hw/usfb_pkg.sv ----
// constants, register map and carrier types of the ultrasonic fire burst and stop mask block
package usfb_pkg;
    localparam int CLK_NS = 100;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FIRE = 8'h04;
    localparam logic [7:0] ADDR_THR = 8'h08;
    localparam logic [7:0] ADDR_REL = 8'h0c;
    localparam logic [7:0] ADDR_DLY1 = 8'h10;
    localparam logic [7:0] ADDR_DLY2 = 8'h14;
    localparam logic [7:0] ADDR_DLY3 = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1c;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    localparam logic [7:0] ADDR_HIT0 = 8'h24;
    localparam logic [7:0] ADDR_HIT1 = 8'h28;
    localparam logic [7:0] ADDR_HIT2 = 8'h2c;
    localparam logic [7:0] ADDR_PWR = 8'h30;
    localparam int CMD_SINGLE_BIT = 0;
    localparam int CMD_UPDOWN_BIT = 1;
    localparam logic [15:0] DLY1_RST = 16'h1388;
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam logic [31:0] FIRE_RST = 32'h0000_1101;
    localparam logic [6:0] RANGE_MV = 7'h14;
    localparam int RATIO_FRAC = 8;
    localparam int T50_NS = 20_000_000;
    localparam int T60_NS = 16_670_000;
    localparam int P50_CYC = (T50_NS + CLK_NS - 1) / CLK_NS;
    localparam int P60_CYC = (T60_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic pw_disable;
        logic pos_offset_range;
        logic neg_offset_range;
        logic fwd_neg_edge;
        logic fwd_enable;
        logic mains_60_select;
        logic fire_idle_level;
        logic internal_start;
        logic dual_drive;
        logic fire_down_sel;
    } usfb_ctrl_t;

    typedef struct packed {
        logic [15:0] phase;
        logic [3:0] repeat_cnt;
        logic [3:0] div;
        logic pad;
        logic [6:0] burst_pulse_count;
    } usfb_fire_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FIRE, ST_MEAS, ST_PAUSE} usfb_state_t;
endpackage

// ---- hw/usfb_core.sv ----
// fire burst generator, up/down sequencer, stop masking and first wave capture
//
// The address map and the plain strobed port were left to the implementer.
module usfb_core #(
    parameter int unsigned PERIOD_50_CYC = usfb_pkg::P50_CYC,
    parameter int unsigned PERIOD_60_CYC = usfb_pkg::P60_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ext_start,
    input wire logic stop_in,
    output logic fire_up,
    output logic fire_up_oe,
    output logic fire_down,
    output logic fire_down_oe,
    output logic signed [6:0] fwd_thresh_mv,
    output logic fwd_edge_fall,
    output logic busy
);
    usfb_pkg::usfb_ctrl_t ctrl;
    usfb_pkg::usfb_fire_t fcfg;
    usfb_pkg::usfb_state_t state, next_state;
    logic [4:0] var_thr;
    logic [7:0] pause_cnt;
    logic [5:0] rel_sel [3];
    logic [15:0] dly [3];
    logic cmd_single, cmd_updown, launch, burst_done, meas_end;
    logic dir_down, updown, second;
    logic [7:0] pause_left;
    logic [17:0] mains_cnt;
    logic mains_tick;
    logic [3:0] div_cnt, div_eff, rep_idx, rep_eff;
    logic [6:0] pulse_idx, cnt_eff;
    logic half, fire_tick, phase_bit, burst_lvl, up_act, dn_act;
    logic ext_prev, ext_edge, start_evt, tof_run, in_win;
    logic [15:0] tof_timer;
    logic stop_prev, fwd, act, trail;
    logic [2:0] st, hit_vld;
    logic [15:0] hit_t [3];
    logic [1:0] n_hit;
    logic fw_found, fw_det, fw_open, hw_open, fw_wv, hw_wv;
    logic [5:0] rel_cnt, next_rel;
    logic [15:0] fw_t, fw_w, hw;
    logic div_busy, div_go, ratio_vld;
    logic [4:0] div_step;
    logic [16:0] rem, rem_sh;
    logic [23:0] quo;
    logic [15:0] pw_ratio;

    // edge of the chosen polarity between two samples
    function automatic logic edge_of(input logic prev, input logic cur, input logic fall);
        edge_of = fall ? (prev & ~cur) : (~prev & cur);
    endfunction

    // software registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= usfb_pkg::usfb_ctrl_t'(usfb_pkg::CTRL_RST);
            fcfg <= usfb_pkg::usfb_fire_t'(usfb_pkg::FIRE_RST);
            var_thr <= 5'h00;
            pause_cnt <= 8'h00;
            rel_sel[0] <= 6'h01;
            rel_sel[1] <= 6'h02;
            rel_sel[2] <= 6'h03;
            dly[0] <= usfb_pkg::DLY1_RST;
            dly[1] <= 16'h0000;
            dly[2] <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                usfb_pkg::ADDR_CTRL: ctrl <= usfb_pkg::usfb_ctrl_t'(reg_wdata[9:0]);
                usfb_pkg::ADDR_FIRE: fcfg <= usfb_pkg::usfb_fire_t'(reg_wdata);
                usfb_pkg::ADDR_THR: begin
                    var_thr <= reg_wdata[4:0];
                    pause_cnt <= reg_wdata[15:8];
                end
                usfb_pkg::ADDR_REL: begin
                    rel_sel[0] <= reg_wdata[5:0];
                    rel_sel[1] <= reg_wdata[13:8];
                    rel_sel[2] <= reg_wdata[21:16];
                end
                usfb_pkg::ADDR_DLY1: dly[0] <= reg_wdata[15:0];
                usfb_pkg::ADDR_DLY2: dly[1] <= reg_wdata[15:0];
                usfb_pkg::ADDR_DLY3: dly[2] <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    assign cmd_single = reg_wr && reg_addr == usfb_pkg::ADDR_CMD
        && reg_wdata[usfb_pkg::CMD_SINGLE_BIT];
    assign cmd_updown = reg_wr && reg_addr == usfb_pkg::ADDR_CMD
        && reg_wdata[usfb_pkg::CMD_UPDOWN_BIT];

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                usfb_pkg::ADDR_CTRL: reg_rdata <= {22'h000000, ctrl};
                usfb_pkg::ADDR_FIRE: reg_rdata <= fcfg;
                usfb_pkg::ADDR_THR: reg_rdata <= {16'h0000, pause_cnt, 3'h0, var_thr};
                usfb_pkg::ADDR_REL: reg_rdata <= {10'h000, rel_sel[2], 2'h0, rel_sel[1],
                    2'h0, rel_sel[0]};
                usfb_pkg::ADDR_DLY1: reg_rdata <= {16'h0000, dly[0]};
                usfb_pkg::ADDR_DLY2: reg_rdata <= {16'h0000, dly[1]};
                usfb_pkg::ADDR_DLY3: reg_rdata <= {16'h0000, dly[2]};
                usfb_pkg::ADDR_STAT: reg_rdata <= {17'h00000, fwd_thresh_mv, ratio_vld,
                    fw_found, hit_vld, second, dir_down, busy};
                usfb_pkg::ADDR_HIT0: reg_rdata <= {16'h0000, hit_t[0]};
                usfb_pkg::ADDR_HIT1: reg_rdata <= {16'h0000, hit_t[1]};
                usfb_pkg::ADDR_HIT2: reg_rdata <= {16'h0000, hit_t[2]};
                usfb_pkg::ADDR_PWR: reg_rdata <= {16'h0000, pw_ratio};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // threshold sum goes to the analog comparator; -36..+35 mV fits seven bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fwd_thresh_mv <= 7'h00;
            fwd_edge_fall <= 1'b0;
        end else begin
            fwd_thresh_mv <= 7'({{2{var_thr[4]}}, var_thr}
                + (ctrl.pos_offset_range ? usfb_pkg::RANGE_MV : 7'h00)
                - (ctrl.neg_offset_range ? usfb_pkg::RANGE_MV : 7'h00));
            fwd_edge_fall <= ctrl.fwd_enable & ctrl.fwd_neg_edge;
        end
    end

    // sequencer
    assign mains_tick = mains_cnt == (ctrl.mains_60_select ? 18'(PERIOD_60_CYC - 1)
        : 18'(PERIOD_50_CYC - 1));
    assign launch = state != usfb_pkg::ST_FIRE && next_state == usfb_pkg::ST_FIRE;
    assign meas_end = state == usfb_pkg::ST_MEAS && (&hit_vld || &tof_timer);

    always_comb begin
        next_state = state;
        case (state)
            usfb_pkg::ST_IDLE: if (cmd_single || cmd_updown) next_state = usfb_pkg::ST_FIRE;
            usfb_pkg::ST_FIRE: if (burst_done) next_state = usfb_pkg::ST_MEAS;
            usfb_pkg::ST_MEAS: begin
                if (meas_end) begin
                    if (updown && !second) begin
                        next_state = pause_cnt == 8'h00 ? usfb_pkg::ST_FIRE : usfb_pkg::ST_PAUSE;
                    end else begin
                        next_state = usfb_pkg::ST_IDLE;
                    end
                end
            end
            usfb_pkg::ST_PAUSE: begin
                if (mains_tick && pause_left == 8'h01) next_state = usfb_pkg::ST_FIRE;
            end
            default: next_state = usfb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= usfb_pkg::ST_IDLE;
            dir_down <= 1'b0;
            updown <= 1'b0;
            second <= 1'b0;
            pause_left <= 8'h00;
            mains_cnt <= 18'h00000;
        end else begin
            state <= next_state;
            if (state == usfb_pkg::ST_IDLE && launch) begin
                dir_down <= ctrl.fire_down_sel;
                updown <= cmd_updown;
                second <= 1'b0;
            end
            if (state == usfb_pkg::ST_MEAS && meas_end && updown && !second) begin
                second <= 1'b1;
                dir_down <= ~dir_down;
                pause_left <= pause_cnt;
                mains_cnt <= 18'h00000;
            end else if (state == usfb_pkg::ST_PAUSE) begin
                mains_cnt <= mains_tick ? 18'h00000 : mains_cnt + 18'h00001;
                if (mains_tick) pause_left <= pause_left - 8'h01;
            end
        end
    end

    assign busy = state != usfb_pkg::ST_IDLE;

    // burst generator; a zero setting is taken as the smallest legal one
    assign div_eff = fcfg.div == 4'h0 ? 4'h1 : fcfg.div;
    assign cnt_eff = fcfg.burst_pulse_count == 7'h00 ? 7'h01 : fcfg.burst_pulse_count;
    assign rep_eff = fcfg.repeat_cnt == 4'h0 ? 4'h1 : fcfg.repeat_cnt;
    assign fire_tick = state == usfb_pkg::ST_FIRE && div_cnt == div_eff;
    assign burst_done = fire_tick && half && pulse_idx == cnt_eff - 7'h01
        && rep_idx == rep_eff - 4'h1;
    // only sixteen phase bits exist; later pulses use the high-then-low shape
    assign phase_bit = pulse_idx < 7'h10 ? fcfg.phase[pulse_idx[3:0]] : 1'b0;
    assign burst_lvl = half ? phase_bit : ~phase_bit;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || launch) begin
            div_cnt <= 4'h0;
            half <= 1'b0;
            pulse_idx <= 7'h00;
            rep_idx <= 4'h0;
        end else if (state == usfb_pkg::ST_FIRE) begin
            div_cnt <= fire_tick ? 4'h0 : div_cnt + 4'h1;
            if (fire_tick) begin
                half <= ~half;
                if (half) begin
                    if (pulse_idx == cnt_eff - 7'h01) begin
                        pulse_idx <= 7'h00;
                        rep_idx <= rep_idx + 4'h1;
                    end else begin
                        pulse_idx <= pulse_idx + 7'h01;
                    end
                end
            end
        end
    end

    // pad drivers; outputs are one cycle behind the burst level
    assign up_act = !dir_down || ctrl.dual_drive;
    assign dn_act = dir_down || ctrl.dual_drive;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fire_up <= 1'b0;
            fire_up_oe <= 1'b0;
            fire_down <= 1'b0;
            fire_down_oe <= 1'b0;
        end else if (state == usfb_pkg::ST_FIRE) begin
            fire_up <= up_act & burst_lvl;
            fire_up_oe <= up_act | ctrl.fire_idle_level;
            fire_down <= dn_act & (ctrl.dual_drive ? ~burst_lvl : burst_lvl);
            fire_down_oe <= dn_act | ctrl.fire_idle_level;
        end else begin
            fire_up <= 1'b0;
            fire_up_oe <= ctrl.fire_idle_level;
            fire_down <= 1'b0;
            fire_down_oe <= ctrl.fire_idle_level;
        end
    end

    // start and time base of the masking windows
    assign ext_edge = ext_start & ~ext_prev;
    assign in_win = tof_run && (state == usfb_pkg::ST_FIRE || state == usfb_pkg::ST_MEAS);
    assign start_evt = ctrl.internal_start ? launch
        : ext_edge && !tof_run && !launch
          && (state == usfb_pkg::ST_FIRE || state == usfb_pkg::ST_MEAS);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_prev <= 1'b0;
            stop_prev <= 1'b0;
            tof_run <= 1'b0;
            tof_timer <= 16'h0000;
        end else begin
            ext_prev <= ext_start;
            stop_prev <= stop_in;
            if (start_evt) begin
                tof_run <= 1'b1;
                tof_timer <= 16'h0000;
            end else if (launch) begin
                tof_run <= 1'b0;
                tof_timer <= 16'h0000;
            end else if ((state == usfb_pkg::ST_FIRE || state == usfb_pkg::ST_MEAS)
                && !(&tof_timer)) begin
                tof_timer <= tof_timer + 16'h0001;
            end
        end
    end

    // stop hit acceptance
    assign fwd = ctrl.fwd_enable;
    assign act = edge_of(stop_prev, stop_in, fwd_edge_fall);
    assign trail = edge_of(stop_prev, stop_in, ~fwd_edge_fall);
    assign next_rel = rel_cnt + 6'h01;
    assign fw_det = in_win && act && fwd && !fw_found && tof_timer >= dly[0];

    for (genvar k = 0; k < 3; k++) begin : g_store
        assign st[k] = in_win && act && (fwd
            ? fw_found && !hit_vld[k] && next_rel == rel_sel[k]
            : n_hit == 2'(k) && tof_timer >= dly[k]);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || launch) begin
            hit_vld <= 3'h0;
            n_hit <= 2'h0;
            fw_found <= 1'b0;
            rel_cnt <= 6'h00;
            fw_t <= 16'h0000;
            for (int i = 0; i < 3; i++) hit_t[i] <= 16'h0000;
        end else begin
            if (fw_det) begin
                fw_found <= 1'b1;
                fw_t <= tof_timer;
            end else if (in_win && act && fw_found) begin
                rel_cnt <= next_rel;
            end
            for (int i = 0; i < 3; i++) begin
                if (st[i]) begin
                    hit_t[i] <= tof_timer;
                    hit_vld[i] <= 1'b1;
                end
            end
            if (|st && !fwd) n_hit <= n_hit + 2'h1;
        end
    end

    // pulse widths, measured edge to opposite edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n || launch) begin
            fw_open <= 1'b0;
            hw_open <= 1'b0;
            fw_wv <= 1'b0;
            hw_wv <= 1'b0;
            fw_w <= 16'h0000;
            hw <= 16'h0000;
        end else begin
            if (fw_det) fw_open <= 1'b1;
            if (st[0] && fwd) hw_open <= 1'b1;
            if (trail && fw_open) begin
                fw_open <= 1'b0;
                fw_wv <= 1'b1;
                fw_w <= tof_timer - fw_t;
            end
            if (trail && hw_open) begin
                hw_open <= 1'b0;
                hw_wv <= 1'b1;
                hw <= tof_timer - hit_t[0];
            end
        end
    end

    // ratio in 16.8 fixed point by a restoring divider, one quotient bit a cycle; pw_ratio keeps the integer part
    assign div_go = fw_wv && hw_wv && !ctrl.pw_disable && !div_busy && !ratio_vld;
    assign rem_sh = {rem[15:0], quo[23]};
    always_ff @(posedge sys_clk) begin
        if (!rst_n || launch) begin
            div_busy <= 1'b0;
            ratio_vld <= 1'b0;
            div_step <= 5'h00;
            rem <= 17'h00000;
            quo <= 24'h000000;
        end else if (div_go) begin
            div_busy <= 1'b1;
            div_step <= 5'h00;
            rem <= 17'h00000;
            quo <= {fw_w, 8'h00};
        end else if (div_busy) begin
            if (rem_sh >= {1'b0, hw}) begin
                rem <= rem_sh - {1'b0, hw};
                quo <= {quo[22:0], 1'b1};
            end else begin
                rem <= rem_sh;
                quo <= {quo[22:0], 1'b0};
            end
            div_step <= div_step + 5'h01;
            if (div_step == 5'h17) begin
                div_busy <= 1'b0;
                ratio_vld <= 1'b1;
            end
        end
    end

    // the ratio is kept across runs until a new one completes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) pw_ratio <= 16'h0000;
        else if (div_busy && div_step == 5'h17) pw_ratio <= quo[22:7];
    end

    AST_IDLE_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(state) != usfb_pkg::ST_FIRE && $past(state) == usfb_pkg::ST_IDLE
        |-> !fire_up && !fire_down && fire_up_oe == $past(ctrl.fire_idle_level))
        else $error("idle fire buffer level wrong");
    AST_DUAL_INV: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(state) == usfb_pkg::ST_FIRE && $past(ctrl.dual_drive)
        |-> fire_down == !fire_up && fire_down_oe && fire_up_oe)
        else $error("down output not inverted burst");
    AST_UP_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(state) == usfb_pkg::ST_FIRE && !$past(dir_down) && !$past(ctrl.dual_drive)
        |-> fire_up_oe && !fire_down)
        else $error("up burst not on up output");
    AST_MASK1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st[0] && !fwd |-> tof_timer >= dly[0] && n_hit == 2'h0)
        else $error("first hit accepted inside mask");
    AST_MASK2: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st[1] && !fwd |-> tof_timer >= dly[1] && hit_vld[0])
        else $error("second hit accepted inside mask");
    AST_MASK3: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st[2] && !fwd |-> tof_timer >= dly[2] ##1 &hit_vld)
        else $error("third hit accepted inside mask");
    AST_FWD_WIN1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fwd && in_win && act && tof_timer < dly[0] && !fw_found && !launch
        |=> !fw_found && $stable(hit_vld))
        else $error("hit accepted before first window");
    AST_EXT_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrl.internal_start && ext_edge && !launch |=> $stable(tof_timer) || tof_timer != 16'h0000)
        else $error("external start restarted timer");
    AST_PAUSE_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == usfb_pkg::ST_PAUSE && mains_tick && pause_left == 8'h01
        |=> state == usfb_pkg::ST_FIRE && dir_down == $past(dir_down))
        else $error("pause did not end on count");
    AST_HALF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fire_tick && !burst_done |=> !fire_tick [*1] ##0 state == usfb_pkg::ST_FIRE)
        else $error("burst half period too short");
    AST_BURST_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == usfb_pkg::ST_FIRE && next_state == usfb_pkg::ST_MEAS
        |-> pulse_idx == cnt_eff - 7'h01 && half && rep_idx == rep_eff - 4'h1)
        else $error("burst ended at wrong pulse");
    COV_UPDOWN: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state == usfb_pkg::ST_PAUSE ##[1:1000] state == usfb_pkg::ST_FIRE);
    COV_FWD_HITS: cover property (@(posedge sys_clk) disable iff (!rst_n)
        fwd && &hit_vld);
    COV_RATIO: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(ratio_vld));
endmodule

// ---- bench/usfb_echo.sv ----
// partner: transducer pair and receive comparator, one echo train per burst
module usfb_echo (
    input wire logic sys_clk,
    input wire logic fire_up,
    input wire logic fire_up_oe,
    input wire logic fire_down,
    input wire logic fire_down_oe,
    output logic stop_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic oe_prev = 1'b0;
    // a newly enabled buffer starts a fresh train, so a tail left from the last run cannot mask it
    always @(posedge sys_clk) begin
        oe_prev <= fire_up_oe | fire_down_oe;
        if ((fire_up_oe | fire_down_oe) & ~oe_prev) cnt <= 1;
        else if (cnt != 0) cnt <= (cnt == 90) ? 0 : cnt + 1;
        else if ((fire_up & fire_up_oe) | (fire_down & fire_down_oe)) cnt <= 1;
    end
    // two-cycle hits 10, 20 .. 70 cycles after the burst front
    assign stop_in = cnt >= 10 && cnt <= 71 && cnt % 10 < 2;
endmodule

// ---- bench/usfb_core_tb.sv ----
// self-checking bench for the fire burst and stop mask block
module usfb_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ext_start = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic stop_in, fire_up, fire_up_oe, fire_down, fire_down_oe, fwd_edge_fall, busy, f1, f2;
    logic signed [6:0] fwd_thresh_mv;
    int bad_count = 0, samples_checked = 0, g50, g60;
    initial forever #50 sys_clk = ~sys_clk;
    // short mains periods keep the pause in reach: 20 and 17 cycles
    usfb_core #(.PERIOD_50_CYC(20), .PERIOD_60_CYC(17)) usfb_core_i (.*);
    usfb_echo usfb_echo_i (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic idle;
        repeat (2) @(posedge sys_clk);
        for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge sys_clk);
    endtask
    task automatic burst(input logic [9:0] c, input logic [31:0] f, input logic dn, input logic inv);
        int h;
        h = f[11:8] + 1;
        wr(usfb_pkg::ADDR_CTRL, {22'h0, c});
        wr(usfb_pkg::ADDR_FIRE, f);
        wr(usfb_pkg::ADDR_CMD, 32'h1);
        // pins show the first half one edge after the state enters the burst
        repeat (1) @(posedge sys_clk);
        for (int i = 0; i < f[15:12] * f[6:0] * 2 * h; i++) begin
            #1 chk(dn ? fire_down : fire_up, ((i % (2 * h)) < h) ^ f[16 + (i / (2 * h)) % f[6:0]] ^ inv);
            @(posedge sys_clk);
        end
        idle;
        $display("burst test done");
    endtask
    task automatic ud(input logic [9:0] c, output int gap, output logic a, output logic b);
        gap = 0;
        wr(usfb_pkg::ADDR_CTRL, {22'h0, c});
        wr(usfb_pkg::ADDR_CMD, 32'h2);
        for (int k = 0; k < 50 && !(fire_up_oe | fire_down_oe); k++) @(posedge sys_clk);
        a = fire_down_oe;
        for (int k = 0; k < 50 && (fire_up_oe | fire_down_oe); k++) @(posedge sys_clk);
        for (int k = 0; k < 900 && !(fire_up_oe | fire_down_oe); k++) @(posedge sys_clk) gap++;
        b = fire_down_oe;
        idle;
        $display("up/down test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(usfb_pkg::ADDR_FIRE, d);
        chk(d, 32'h1101);
        rd(usfb_pkg::ADDR_DLY1, d);
        chk(d, 32'h1388);
        rd(usfb_pkg::ADDR_REL, d);
        chk(d, 32'h0003_0201);
        rd(8'h34, d);
        chk({d, fire_up_oe, fire_down_oe}, 34'h0);
        wr(usfb_pkg::ADDR_DLY1, 32'h0);
        burst(10'h004, 32'h0002_1102, 1'b0, 1'b0);
        burst(10'h005, 32'h0001_2203, 1'b1, 1'b0);
        burst(10'h006, 32'h0000_1101, 1'b1, 1'b1);
        wr(usfb_pkg::ADDR_CTRL, 32'h008);
        repeat (2) @(posedge sys_clk);
        chk({fire_up_oe, fire_up, fire_down_oe, fire_down}, 4'b1010);
        wr(usfb_pkg::ADDR_CTRL, 32'h000);
        repeat (2) @(posedge sys_clk);
        chk({fire_up_oe, fire_down_oe}, 2'b00);
        wr(usfb_pkg::ADDR_DLY1, 32'd30);
        wr(usfb_pkg::ADDR_DLY2, 32'd55);
        wr(usfb_pkg::ADDR_CTRL, 32'h004);
        wr(usfb_pkg::ADDR_CMD, 32'h1);
        idle;
        rd(usfb_pkg::ADDR_HIT0, d);
        chk(d[15:0] >= 30 && d[15:0] <= 38, 1);
        rd(usfb_pkg::ADDR_HIT1, d);
        chk(d[15:0] >= 55 && d[15:0] <= 66, 1);
        wr(usfb_pkg::ADDR_THR, 32'h0000_0210);
        wr(usfb_pkg::ADDR_CTRL, 32'h0e0);
        repeat (3) @(posedge sys_clk);
        chk({fwd_thresh_mv, fwd_edge_fall}, {7'h5c, 1'b1});
        wr(usfb_pkg::ADDR_THR, 32'h0000_020f);
        wr(usfb_pkg::ADDR_CTRL, 32'h120);
        repeat (3) @(posedge sys_clk);
        chk({fwd_thresh_mv, fwd_edge_fall}, {7'h23, 1'b0});
        $display("threshold test done");
        ud(10'h005, g50, f1, f2);
        chk({f1, f2}, 2'b10);
        ud(10'h014, g60, f1, f2);
        chk({f1, f2}, 2'b01);
        chk(g50 - g60, 6);
        test_done;
    end
endmodule
